//--- verilog/fci_defs.svh
`ifndef FCI_DEFS_SVH
`define FCI_DEFS_SVH
// ----------------------------------------
// Command addresses and data
// ----------------------------------------
`define FCI_ADDR_UNLOCK1 16'h0555
`define FCI_ADDR_UNLOCK2 16'h02aa
`define FCI_ADDR_ANY 16'h0000
`define FCI_DATA_UNLOCK1 16'h00aa
`define FCI_DATA_UNLOCK2 16'h0055
`define FCI_DATA_RESET 16'h00f0
`define FCI_DATA_AUTOSEL 16'h0090
`define FCI_DATA_PROGRAM 16'h00a0
`define FCI_DATA_BYPASS 16'h0020
`define FCI_DATA_BYPASS_RST 16'h0000
`define FCI_DATA_ERASE 16'h0080
`define FCI_DATA_CHIP_ERASE 16'h0010
`define FCI_DATA_BLOCK_ERASE 16'h0030
`define FCI_DATA_SUSPEND 16'h00b0
`define FCI_DATA_RESUME 16'h0030
// ----------------------------------------
// Auto select read addresses
// ----------------------------------------
`define FCI_ASEL_MANUF 16'h0000
`define FCI_ASEL_DEVICE 16'h0001
`define FCI_ASEL_PROTECT 16'h0002
`define FCI_ASEL_BLOCK_POS 12
// ----------------------------------------
// Bus timing
// ----------------------------------------
`define FCI_CLK_PERIOD_NS 5
`define FCI_MIN_PULSE_NS 5
`define FCI_SETUP_NS 30
`define FCI_PULSE_NS 45
`define FCI_RECOVER_NS 30
`define FCI_IDLE_NS 150
`define FCI_ABORT_US 10
`define FCI_NS2CYC(t) (((t) + `FCI_CLK_PERIOD_NS - 1) / `FCI_CLK_PERIOD_NS)
`endif

//--- verilog/fci_pkg.sv
package fci_pkg;
  typedef enum logic [3:0] {
    FCI_CMD_READ_RESET,
    FCI_CMD_READ_RESET3,
    FCI_CMD_AUTO_SELECT,
    FCI_CMD_PROGRAM,
    FCI_CMD_BYPASS,
    FCI_CMD_BYPASS_PROGRAM,
    FCI_CMD_BYPASS_RESET,
    FCI_CMD_CHIP_ERASE,
    FCI_CMD_BLOCK_ERASE,
    FCI_CMD_BLOCK_ADD,
    FCI_CMD_SUSPEND,
    FCI_CMD_RESUME,
    FCI_CMD_READ,
    FCI_CMD_ASEL_READ
  } fci_cmd_e;
  typedef enum logic [1:0] {
    FCI_CYC_WRITE,
    FCI_CYC_READ
  } fci_cyc_e;
endpackage : fci_pkg

//--- verilog/fci_cycle_if.sv
`timescale 1ns/100ps
interface fci_cycle_if;
  logic start;
  fci_pkg::fci_cyc_e kind;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport seq (output start, kind, addr, wdata, input rdata, done);
  modport bus (input start, kind, addr, wdata, output rdata, done);
endinterface : fci_cycle_if

//--- verilog/fci_bus_cycle.sv
`timescale 1ns/100ps
`include "fci_defs.svh"
module fci_bus_cycle #(
  parameter int SetupCyc = `FCI_NS2CYC(`FCI_SETUP_NS),
  parameter int PulseCyc = `FCI_NS2CYC(`FCI_PULSE_NS),
  parameter int RecoverCyc = `FCI_NS2CYC(`FCI_RECOVER_NS)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Sequencer side
  fci_cycle_if.bus cyc,
  // Flash pins
  output logic chipEnableN,
  output logic outputEnableN,
  output logic writeEnableN,
  output logic [15:0] wordSelectLines,
  output logic [15:0] bidirDataLinesOut,
  output logic bidirDataLinesOeN,
  input wire logic [15:0] bidirDataLinesIn
);
  localparam int MinPulse = `FCI_NS2CYC(`FCI_MIN_PULSE_NS);

  // Counters are eight bits wide; strobes must outlast any glitch
  if (PulseCyc <= MinPulse || SetupCyc < 1 || RecoverCyc < 1 || PulseCyc > 255 ||
      SetupCyc > 255 || RecoverCyc > 255) begin : g_bad_timing
    $error("fci_bus_cycle: timing parameters out of range");
  end

  typedef enum logic [1:0] {IDLE, SETUP, PULSE, RECOVER} fci_phase_e;
  fci_phase_e phase_q;
  logic [7:0] cnt_q;
  logic isRead_q;

  // ----------------------------------------
  // Cycle sequencing
  // ----------------------------------------
  // Address set while strobes high; CE and WE fall together after setup, so
  // the address is stable on their shared falling edge.
  // Data held past the rising strobes during recovery.
  // Strobes held far longer than any glitch.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      phase_q <= IDLE;
      cnt_q <= 8'h00;
      isRead_q <= 1'b0;
      chipEnableN <= 1'b1;
      outputEnableN <= 1'b1;
      writeEnableN <= 1'b1;
      wordSelectLines <= 16'h0000;
      bidirDataLinesOut <= 16'h0000;
      bidirDataLinesOeN <= 1'b1;
      cyc.rdata <= 16'h0000;
      cyc.done <= 1'b0;
    end else begin
      cyc.done <= 1'b0;
      unique case (phase_q)
        IDLE: begin
          if (cyc.start) begin
            isRead_q <= (cyc.kind == fci_pkg::FCI_CYC_READ);
            wordSelectLines <= cyc.addr;
            bidirDataLinesOut <= cyc.wdata;
            // Release data lines on reads, OE stays high on writes
            bidirDataLinesOeN <= (cyc.kind == fci_pkg::FCI_CYC_READ);
            cnt_q <= 8'(SetupCyc);
            phase_q <= SETUP;
          end
        end
        SETUP: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            chipEnableN <= 1'b0;
            // Read: CE low, OE low, WE high
            outputEnableN <= !isRead_q;
            writeEnableN <= isRead_q;
            cnt_q <= 8'(PulseCyc);
            phase_q <= PULSE;
          end
        end
        PULSE: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            if (isRead_q) begin
              cyc.rdata <= bidirDataLinesIn;
            end
            chipEnableN <= 1'b1;
            outputEnableN <= 1'b1;
            writeEnableN <= 1'b1;
            cnt_q <= 8'(RecoverCyc);
            phase_q <= RECOVER;
          end
        end
        RECOVER: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            bidirDataLinesOeN <= 1'b1;
            cyc.done <= 1'b1;
            phase_q <= IDLE;
          end
        end
      endcase
    end
  end
endmodule : fci_bus_cycle

//--- verilog/fci_host.sv
// Operation
// - Reads drive chip and output enable low, write enable high.
// - Output enable stays high throughout every write.
// - Read/reset is F0 alone or 555/AA, 2AA/55, F0.
// - Auto select is 555/AA, 2AA/55, 555/90 and persists.
// - Program is 555/AA, 2AA/55, 555/A0 then target location and value.
// - Unlock bypass is 555/AA, 2AA/55, 555/20.
// - Bypass program is A0 then target location and value.
// - Bypass reset is 90 then 00 to any address.
// - Chip erase is six writes ending 555/10.
// - Block erase ends with block address/30; repeat to add blocks.
`timescale 1ns/100ps
`include "fci_defs.svh"
module fci_host #(
  parameter int AbortCyc = (`FCI_ABORT_US * 1000) / `FCI_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Command port
  input wire logic cmdValid,
  input wire fci_pkg::fci_cmd_e cmdCode,
  input wire logic [15:0] cmdAddr,
  input wire logic [15:0] cmdData,
  output logic cmdReady,
  output logic rspValid,
  output logic [15:0] rspData,
  // Flash pins
  output logic chipEnableN,
  output logic outputEnableN,
  output logic writeEnableN,
  output logic [15:0] wordSelectLines,
  output logic [15:0] bidirDataLinesOut,
  output logic bidirDataLinesOeN,
  input wire logic [15:0] bidirDataLinesIn
);
  // Abort counter is sixteen bits wide
  if (AbortCyc < 1 || AbortCyc > 65535) begin : g_bad_abort
    $error("fci_host: AbortCyc out of range");
  end

  fci_cycle_if cyc ();

  fci_bus_cycle u_cycle (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cyc(cyc),
    .chipEnableN(chipEnableN),
    .outputEnableN(outputEnableN),
    .writeEnableN(writeEnableN),
    .wordSelectLines(wordSelectLines),
    .bidirDataLinesOut(bidirDataLinesOut),
    .bidirDataLinesOeN(bidirDataLinesOeN),
    .bidirDataLinesIn(bidirDataLinesIn)
  );

  // ----------------------------------------
  // Sequence table
  // ----------------------------------------
  typedef enum logic [1:0] {IDLE, ISSUE, WAIT, ABORT} fci_state_e;
  fci_state_e state_q;
  logic [2:0] step_q;
  logic [2:0] len_q;
  fci_pkg::fci_cmd_e code_q;
  logic [15:0] userAddr_q;
  logic [15:0] userData_q;
  logic [15:0] abortCnt_q;
  logic stepRead;
  logic [15:0] stepAddr;
  logic [15:0] stepData;
  logic [2:0] cmdLen;

  function automatic logic [2:0] seqLen(input fci_pkg::fci_cmd_e c);
    unique case (c)
      fci_pkg::FCI_CMD_READ_RESET3, fci_pkg::FCI_CMD_AUTO_SELECT,
      fci_pkg::FCI_CMD_BYPASS: seqLen = 3'd3;
      fci_pkg::FCI_CMD_PROGRAM: seqLen = 3'd4;
      fci_pkg::FCI_CMD_BYPASS_PROGRAM, fci_pkg::FCI_CMD_BYPASS_RESET: seqLen = 3'd2;
      fci_pkg::FCI_CMD_CHIP_ERASE, fci_pkg::FCI_CMD_BLOCK_ERASE: seqLen = 3'd6;
      default: seqLen = 3'd1;
    endcase
  endfunction : seqLen

  assign cmdLen = seqLen(cmdCode);

  // Address and data of the current step
  always_comb begin
    stepRead = 1'b0;
    stepAddr = `FCI_ADDR_ANY;
    stepData = `FCI_DATA_RESET;
    // Unlock prefix shared by long sequences
    // Second unlock pair only in the six-write erase sequences
    if (len_q >= 3'd3 && (step_q == 3'd0 || (len_q == 3'd6 && step_q == 3'd3))) begin
      stepAddr = `FCI_ADDR_UNLOCK1;
      stepData = `FCI_DATA_UNLOCK1;
    end else if (len_q >= 3'd3 && (step_q == 3'd1 || (len_q == 3'd6 && step_q == 3'd4))) begin
      stepAddr = `FCI_ADDR_UNLOCK2;
      stepData = `FCI_DATA_UNLOCK2;
    end else begin
      unique case (code_q)
        fci_pkg::FCI_CMD_READ_RESET, fci_pkg::FCI_CMD_READ_RESET3: begin
          stepData = `FCI_DATA_RESET;
        end
        fci_pkg::FCI_CMD_AUTO_SELECT: begin
          stepAddr = `FCI_ADDR_UNLOCK1;
          stepData = `FCI_DATA_AUTOSEL;
        end
        fci_pkg::FCI_CMD_BYPASS: begin
          stepAddr = `FCI_ADDR_UNLOCK1;
          stepData = `FCI_DATA_BYPASS;
        end
        fci_pkg::FCI_CMD_PROGRAM, fci_pkg::FCI_CMD_BYPASS_PROGRAM: begin
          // Final write: target location and value
          if (step_q == len_q - 3'd1) begin
            stepAddr = userAddr_q;
            stepData = userData_q;
          end else begin
            stepAddr = (len_q == 3'd4) ? `FCI_ADDR_UNLOCK1 : `FCI_ADDR_ANY;
            stepData = `FCI_DATA_PROGRAM;
          end
        end
        fci_pkg::FCI_CMD_BYPASS_RESET: begin
          stepData = (step_q == 3'd0) ? `FCI_DATA_AUTOSEL : `FCI_DATA_BYPASS_RST;
        end
        fci_pkg::FCI_CMD_CHIP_ERASE: begin
          stepAddr = `FCI_ADDR_UNLOCK1;
          stepData = (step_q == 3'd2) ? `FCI_DATA_ERASE : `FCI_DATA_CHIP_ERASE;
        end
        fci_pkg::FCI_CMD_BLOCK_ERASE: begin
          stepAddr = (step_q == 3'd2) ? `FCI_ADDR_UNLOCK1 : userAddr_q;
          stepData = (step_q == 3'd2) ? `FCI_DATA_ERASE : `FCI_DATA_BLOCK_ERASE;
        end
        fci_pkg::FCI_CMD_BLOCK_ADD: begin
          stepAddr = userAddr_q;
          stepData = `FCI_DATA_BLOCK_ERASE;
        end
        fci_pkg::FCI_CMD_SUSPEND: begin
          stepData = `FCI_DATA_SUSPEND;
        end
        fci_pkg::FCI_CMD_RESUME: begin
          stepData = `FCI_DATA_RESUME;
        end
        fci_pkg::FCI_CMD_READ: begin
          stepRead = 1'b1;
          stepAddr = userAddr_q;
        end
        fci_pkg::FCI_CMD_ASEL_READ: begin
          // Low bits pick code or protect, top bits the block
          stepRead = 1'b1;
          stepAddr = (userAddr_q & 16'hf000) | (userAddr_q & 16'h0003);
        end
      endcase
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= IDLE;
      step_q <= 3'd0;
      len_q <= 3'd1;
      code_q <= fci_pkg::FCI_CMD_READ;
      userAddr_q <= 16'h0000;
      userData_q <= 16'h0000;
      abortCnt_q <= 16'h0000;
      cmdReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 16'h0000;
      cyc.start <= 1'b0;
      cyc.kind <= fci_pkg::FCI_CYC_WRITE;
      cyc.addr <= 16'h0000;
      cyc.wdata <= 16'h0000;
    end else begin
      rspValid <= 1'b0;
      cyc.start <= 1'b0;
      unique case (state_q)
        IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            code_q <= cmdCode;
            len_q <= cmdLen;
            userAddr_q <= cmdAddr;
            userData_q <= cmdData;
            step_q <= 3'd0;
            state_q <= ISSUE;
          end
        end
        ISSUE: begin
          cyc.start <= 1'b1;
          cyc.kind <= stepRead ? fci_pkg::FCI_CYC_READ : fci_pkg::FCI_CYC_WRITE;
          cyc.addr <= stepAddr;
          cyc.wdata <= stepData;
          state_q <= WAIT;
        end
        WAIT: begin
          if (cyc.done) begin
            if (step_q == len_q - 3'd1) begin
              rspValid <= 1'b1;
              rspData <= cyc.rdata;
              // Resets need the abort wait before reads are valid
              if (code_q == fci_pkg::FCI_CMD_READ_RESET ||
                  code_q == fci_pkg::FCI_CMD_READ_RESET3) begin
                abortCnt_q <= 16'(AbortCyc);
                state_q <= ABORT;
              end else begin
                state_q <= IDLE;
              end
            end else begin
              step_q <= step_q + 3'd1;
              state_q <= ISSUE;
            end
          end
        end
        ABORT: begin
          abortCnt_q <= abortCnt_q - 16'h0001;
          if (abortCnt_q == 16'h0001) begin
            state_q <= IDLE;
          end
        end
      endcase
    end
  end
endmodule : fci_host

//--- testbench/fci_host_chk.sv
`timescale 1ns/100ps
module fci_host_chk #(
  parameter int AbortCyc = 2000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Command port
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic rspValid,
  // Flash pins
  input wire logic chipEnableN,
  input wire logic outputEnableN,
  input wire logic writeEnableN,
  input wire logic [15:0] wordSelectLines,
  input wire logic [15:0] bidirDataLinesOut,
  input wire logic bidirDataLinesOeN
);
  // ----------------------------------------
  // Strobe and handshake checks
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_we_pulse;
    (!writeEnableN) [*8] ##1 !writeEnableN ##1 writeEnableN;
  endsequence
  sequence s_oe_pulse;
    (!outputEnableN) [*8] ##1 !outputEnableN ##1 outputEnableN;
  endsequence
  a_write_pulse: assert property ($fell(writeEnableN) |-> s_we_pulse)
    else $error("write strobe pulse has wrong length");
  a_read_pulse: assert property ($fell(outputEnableN) |-> s_oe_pulse)
    else $error("read strobe pulse has wrong length");
  a_oe_in_write: assert property (!writeEnableN |-> outputEnableN)
    else $error("output enable low during write");
  a_float_on_read: assert property (!outputEnableN |-> bidirDataLinesOeN)
    else $error("host drives data lines during read");
  a_strobe_with_ce: assert property (!(writeEnableN && outputEnableN) |-> !chipEnableN)
    else $error("strobe active without chip enable");
  a_addr_steady: assert property (!chipEnableN |-> $stable(wordSelectLines))
    else $error("address moved while chip enabled");
  a_data_setup: assert property ($fell(writeEnableN) |-> !$past(bidirDataLinesOeN, 6))
    else $error("write data not set up before strobe");
  a_data_hold: assert property (!writeEnableN |-> $stable(bidirDataLinesOut))
    else $error("write data moved during strobe");
  a_ready_drop: assert property (cmdValid && cmdReady |=> !cmdReady)
    else $error("ready stayed high after acceptance");
  a_rsp_single: assert property (rspValid |=> !rspValid)
    else $error("response longer than one cycle");
  a_idle_deselect: assert property (cmdReady |-> chipEnableN)
    else $error("chip enabled while idle");
endmodule : fci_host_chk
bind fci_host fci_host_chk #(.AbortCyc(AbortCyc)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .rspValid(rspValid), .chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
  .writeEnableN(writeEnableN), .wordSelectLines(wordSelectLines),
  .bidirDataLinesOut(bidirDataLinesOut), .bidirDataLinesOeN(bidirDataLinesOeN));

//--- testbench/fci_flash_model.sv
`timescale 1ns/100ps
module fci_flash_model #(
  parameter logic [15:0] ManufCode = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] DevCode = 16'h3c3c, // Arbitrary value
  parameter logic [15:0] StatusVal = 16'h0044,
  parameter logic [3:0] ProtTop = 4'h1,
  parameter int ProgNs = 300
) (
  // Strobes and address
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [15:0] addr,
  // Data lines
  input wire logic [15:0] dqIn,
  output logic [15:0] dqOut
);
  logic [15:0] mem [0:65535];
  logic [15:0] addrQ;
  logic [15:0] rdVal;
  int step = 0;
  bit asel = 0;
  bit byp = 0;
  bit erWin = 0;
  bit wrOn = 0;
  bit busy = 0;
  // Delivered erased
  initial begin
    foreach (mem[k]) mem[k] = 16'hffff;
  end
  // ----------------------------------------
  // Command decoding
  // ----------------------------------------
  task automatic erase(input logic [3:0] top, input bit all);
    foreach (mem[k]) if ((all || k[15:12] == top) && k[15:12] != ProtTop) mem[k] = 16'hffff;
  endtask : erase
  task automatic decode(input logic [15:0] fa, input logic [15:0] fd);
    int s;
    logic [10:0] a;
    logic [7:0] d;
    s = step;
    a = fa[10:0];
    d = fd[7:0];
    step = 0;
    asel = 0;
    if (d == 8'hf0) erWin = 0;
    else if ((s == 3 || s == 7) && fa[15:12] != ProtTop) begin
      mem[fa] = mem[fa] & fd;
      busy = 1;
      busy <= #(ProgNs) 1'b0;
    end else if (s == 3 || s == 7) step = 0;
    else if (byp) begin
      if (d == 8'ha0) step = 7;
      if (d == 8'h90) step = 8;
      if (s == 8 && d == 8'h00) byp = 0;
    end else if (erWin && d == 8'h30) erase(fa[15:12], 0);
    else if (s == 6) begin
      if (d == 8'h10) erase(4'h0, 1);
      if (d == 8'h30) erase(fa[15:12], 0);
      erWin = d == 8'h30;
    end else if (s == 2 && a == 11'h555) begin
      asel = d == 8'h90;
      byp = d == 8'h20;
      step = d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
    end else if (a == (s[0] ? 11'h2aa : 11'h555) && d == (s[0] ? 8'h55 : 8'haa)) step = s + 1;
  endtask : decode
  always @(negedge ceN or negedge weN) begin
    if (!ceN && !weN) begin
      addrQ = addr;
      wrOn = 1;
    end
  end
  always @(posedge ceN or posedge weN) begin
    if (wrOn) begin
      wrOn = 0;
      if (!busy) decode(addrQ, dqIn);
    end
  end
  always @* begin
    if (busy) rdVal = StatusVal;
    else if (asel) rdVal = addr[1] ? {15'h0, addr[15:12] == ProtTop} :
      addr[0] ? DevCode : ManufCode;
    else rdVal = mem[addr];
    dqOut = (!ceN && !oeN) ? rdVal : ~rdVal;
  end
endmodule : fci_flash_model

//--- testbench/flash_command_interface_tb.sv
`timescale 1ns/100ps
module flash_command_interface_tb;
  localparam int AbortCyc = 20;
  localparam logic [15:0] Manuf = 16'h5a5a; // Arbitrary value
  localparam logic [15:0] Dev = 16'h3c3c; // Arbitrary value
  localparam logic [15:0] Stat = 16'h0044;
  logic clk_sys = 0;
  logic resetn = 0;
  logic cmdValid = 0;
  fci_pkg::fci_cmd_e cmdCode = fci_pkg::FCI_CMD_READ;
  logic [15:0] cmdAddr = 16'h0000;
  logic [15:0] cmdData = 16'h0000;
  logic cmdReady, rspValid, ceN, oeN, weN, hostOeN;
  logic [15:0] rspData, addrLines, hostData, flashData, dqWire, rdQ;
  int nErrors = 0;
  int nCompared = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  assign dqWire = hostOeN ? flashData : hostData;
  fci_host #(.AbortCyc(AbortCyc)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .chipEnableN(ceN),
    .outputEnableN(oeN), .writeEnableN(weN), .wordSelectLines(addrLines),
    .bidirDataLinesOut(hostData), .bidirDataLinesOeN(hostOeN), .bidirDataLinesIn(dqWire));
  fci_flash_model #(.ManufCode(Manuf), .DevCode(Dev), .StatusVal(Stat)) u_flash (
    .ceN(ceN), .oeN(oeN), .weN(weN), .addr(addrLines), .dqIn(dqWire), .dqOut(flashData));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finalReport();
    $display("Compared %0d, errors %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finalReport
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nErrors = nErrors + 1;
      finalReport();
    end
  end
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check16
  task automatic issue(input fci_pkg::fci_cmd_e code, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    cmdCode = code;
    cmdAddr = a;
    cmdData = d;
    cmdValid = 1;
    @(negedge clk_sys);
    cmdValid = 0;
    n = 0;
    while (rspValid !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    check16("response", 16'h0001, {15'h0, rspValid});
    rdQ = rspData;
  endtask : issue
  task automatic rd(input logic [15:0] a);
    issue(fci_pkg::FCI_CMD_READ, a, 16'h0000);
  endtask : rd
  task automatic settle(input logic [15:0] a);
    rd(a);
    for (int i = 0; i < 8 && rdQ === Stat; i++) rd(a);
  endtask : settle
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_program();
    rd(16'h0100);
    check16("erased word", 16'hffff, rdQ);
    issue(fci_pkg::FCI_CMD_PROGRAM, 16'h0100, 16'h12f4);
    rd(16'h0100);
    check16("status while busy", Stat, rdQ);
    issue(fci_pkg::FCI_CMD_PROGRAM, 16'h0100, 16'h0000);
    settle(16'h0100);
    check16("programmed word", 16'h12f4, rdQ);
    issue(fci_pkg::FCI_CMD_PROGRAM, 16'h0100, 16'hff0f);
    settle(16'h0100);
    check16("cleared bits only", 16'h1204, rdQ);
    issue(fci_pkg::FCI_CMD_PROGRAM, 16'h1000, 16'h0000);
    rd(16'h1000);
    check16("protected word", 16'hffff, rdQ);
  endtask : t_program
  task automatic t_autosel();
    int n;
    issue(fci_pkg::FCI_CMD_AUTO_SELECT, 16'h0000, 16'h0000);
    issue(fci_pkg::FCI_CMD_ASEL_READ, 16'hf000, 16'h0000);
    check16("maker code", Manuf, rdQ);
    issue(fci_pkg::FCI_CMD_ASEL_READ, 16'h0001, 16'h0000);
    check16("device code", Dev, rdQ);
    issue(fci_pkg::FCI_CMD_ASEL_READ, 16'h1002, 16'h0000);
    check16("protected block", 16'h0001, rdQ);
    issue(fci_pkg::FCI_CMD_ASEL_READ, 16'h2002, 16'h0000);
    check16("open block", 16'h0000, rdQ);
    issue(fci_pkg::FCI_CMD_READ_RESET, 16'h0000, 16'h0000);
    n = 0;
    while (cmdReady !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    check16("abort wait", 16'h0001, {15'h0, n >= AbortCyc});
    rd(16'h0100);
    check16("array after reset", 16'h1204, rdQ);
  endtask : t_autosel
  task automatic t_bypass();
    issue(fci_pkg::FCI_CMD_BYPASS, 16'h0000, 16'h0000);
    rd(16'h0100);
    check16("bypass array read", 16'h1204, rdQ);
    issue(fci_pkg::FCI_CMD_BYPASS_PROGRAM, 16'h0200, 16'h00ff);
    settle(16'h0200);
    check16("bypass program", 16'h00ff, rdQ);
    issue(fci_pkg::FCI_CMD_BYPASS_RESET, 16'h0000, 16'h0000);
    issue(fci_pkg::FCI_CMD_BYPASS_PROGRAM, 16'h0200, 16'h0000);
    rd(16'h0200);
    check16("bypass left", 16'h00ff, rdQ);
  endtask : t_bypass
  task automatic t_erase();
    issue(fci_pkg::FCI_CMD_READ_RESET3, 16'h0000, 16'h0000);
    issue(fci_pkg::FCI_CMD_BLOCK_ERASE, 16'h0200, 16'h0000);
    issue(fci_pkg::FCI_CMD_BLOCK_ADD, 16'h3000, 16'h0000);
    issue(fci_pkg::FCI_CMD_SUSPEND, 16'h0000, 16'h0000);
    issue(fci_pkg::FCI_CMD_RESUME, 16'h0000, 16'h0000);
    rd(16'h0100);
    check16("block erased", 16'hffff, rdQ);
    issue(fci_pkg::FCI_CMD_READ_RESET, 16'h0000, 16'h0000);
    issue(fci_pkg::FCI_CMD_PROGRAM, 16'h5000, 16'h0000);
    settle(16'h5000);
    check16("before chip erase", 16'h0000, rdQ);
    issue(fci_pkg::FCI_CMD_CHIP_ERASE, 16'h0000, 16'h0000);
    rd(16'h5000);
    check16("chip erased", 16'hffff, rdQ);
  endtask : t_erase
  initial begin
    repeat (20) @(negedge clk_sys);
    resetn = 1;
    t_program();
    t_autosel();
    t_bypass();
    t_erase();
    finalReport();
  end
endmodule : flash_command_interface_tb
